// ### verilog/tfa_device.sv
/*
 * Card end: decodes card-mode and fixed-disk cycles onto the task file
 * and a sequential sector buffer.
 * Assumes the host end shares mclk_i and keeps one access per strobe.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tfa_defines.svh"

// Functional notes
// - Memory mode low window decodes address bits 3..0
// - Both enables low: offset 0 is word
// - Low-lane byte pair gives even then odd
// - High-only byte at 0 hits fault/option
// - Offsets 8, 9, D duplicate 0/1
// - Low-lane byte accesses to 0/8 alternate even/odd
// - Word accesses to 0/8/9 advance words
// - Byte accesses to 9 take odd, advance word
// - Window even addresses map 8, odd 9
// - Window is a FIFO, no random access
// - Word at 8: even low, odd high
// - Disk mode selects decode task-file offsets
// - Disk DMA acknowledge moves data words
// - Disk width set by register, byte option
// - Legacy long commands use byte data
// - Odd registers also on upper lane
// - Word access at 1 is data word
// - Duplicates accept every combination; byte-option I/O refuses high-only
// - High-only 8/9 odd; word D fault high
// - Attribute select low I/O, high memory
module tfa_device
#(
   parameter int BUF_WORDS = 256,
   parameter int AW        = $clog2(BUF_WORDS)
)
(
   // Clock and reset
   input  wire logic          mclk_i,
   input  wire logic          sys_rst_i,
   // Card connector
   tfa_if.device              card,
   // Mode and status from the card controller
   input  wire logic          ide_mode_i,
   input  wire logic          byte_mode_i,
   input  wire logic          long_byte_i,
   input  wire logic          sector_start_i,
   input  wire logic [7:0]    status_i,
   input  wire logic [7:0]    error_i,
   input  wire logic [7:0]    drive_addr_i,
   // Sector buffer, controller side
   input  wire logic [AW-1:0] buf_addr_i,
   input  wire logic          buf_we_i,
   input  wire logic [15:0]   buf_wdata_i,
   output logic [15:0]        buf_rdata_o,
   output logic [AW-1:0]      word_ptr_o,
   output logic               odd_ptr_o,
   // Task file, controller side
   output logic [7:0]         option_o,
   output logic [7:0]         count_o,
   output logic [7:0]         block_o,
   output logic [7:0]         track_low_o,
   output logic [7:0]         track_high_o,
   output logic [7:0]         unit_o,
   output logic [7:0]         opcode_o,
   output logic               opcode_stb_o,
   output logic [7:0]         control_o
);
   import tfa_pkg::*;

   tfa_target_t tgt;
   logic [3:0]  off;
   logic        hi_lane;
   logic        mem_cyc;
   logic        rd_q;
   logic        wr_q;
   logic        rd_start;
   logic        wr_start;
   logic [15:0] buf_mem [BUF_WORDS];
   logic [15:0] cur_word;
   logic [7:0]  reg_rd;
   logic [7:0]  wr_byte;

   // ----------------------------------------------------------------------
   // Strobe edges; both ends share the clock so no synchroniser is needed
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         rd_q <= 1'b1;
         wr_q <= 1'b1;
      end
      else
      begin
         rd_q <= card.read_n;
         wr_q <= card.write_n;
      end
   end

   assign rd_start = rd_q & ~card.read_n;
   assign wr_start = wr_q & ~card.write_n;
   assign mem_cyc  = card.attr_select;

   // Card-mode I/O cycles are signalled wide unless the byte option is on; disk mode never is
   assign card.wide_io_indicator_n = ide_mode_i | mem_cyc | byte_mode_i;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      tgt     = TFA_TGT_NONE;
      off     = `TFA_OFF_DATA;
      hi_lane = 1'b0;
      if (ide_mode_i)
      begin
         if (!card.dma_ack_n && card.command_block_select_n
             && card.control_block_select_n)
            tgt = TFA_TGT_WORD;
         else if (card.control_block_select_n && !card.command_block_select_n)
         begin
            off = {1'b0, card.addr[2:0]};
            if (off != `TFA_OFF_DATA)
               tgt = TFA_TGT_REG;
            else if (byte_mode_i || long_byte_i)
               tgt = TFA_TGT_EVEN;
            else
               tgt = TFA_TGT_WORD;
         end
         else if (!card.control_block_select_n && card.command_block_select_n
                  && card.addr[2:0] == `TFA_IDE_SHADOW_ADDR)
         begin
            off = `TFA_OFF_SHADOW;
            tgt = TFA_TGT_REG;
         end
      end
      else
      begin
         if (mem_cyc && card.addr[`TFA_WINDOW_BIT])
            off = {3'b100, card.addr[0]};
         else
            off = card.addr[3:0];
         case ({card.high_lane_enable_n, card.low_lane_enable_n})
            2'b00:
            begin
               if (off == `TFA_OFF_DATA || off == `TFA_OFF_FAULT
                   || off == `TFA_OFF_EVEN_ALIAS || off == `TFA_OFF_ODD_ALIAS)
                  tgt = TFA_TGT_WORD;
               else if (off == `TFA_OFF_FAULT_ALIAS)
               begin
                  tgt     = TFA_TGT_REG;
                  off     = `TFA_OFF_FAULT;
                  hi_lane = 1'b1;
               end
               else
                  tgt = TFA_TGT_REG;
            end
            2'b10:
            begin
               if (off == `TFA_OFF_DATA || off == `TFA_OFF_EVEN_ALIAS)
                  tgt = TFA_TGT_EVEN;
               else if (off == `TFA_OFF_ODD_ALIAS)
                  tgt = TFA_TGT_ODD;
               else
               begin
                  tgt = TFA_TGT_REG;
                  if (off == `TFA_OFF_FAULT_ALIAS)
                     off = `TFA_OFF_FAULT;
               end
            end
            2'b01:
            begin
               hi_lane = 1'b1;
               if (!mem_cyc && card.wide_io_indicator_n)
                  tgt = TFA_TGT_NONE;
               else if (off == `TFA_OFF_DATA)
               begin
                  tgt = TFA_TGT_REG;
                  off = `TFA_OFF_FAULT;
               end
               else if (off == `TFA_OFF_EVEN_ALIAS || off == `TFA_OFF_ODD_ALIAS)
                  tgt = TFA_TGT_ODD;
               else
               begin
                  tgt = TFA_TGT_REG;
                  off = off | 4'h1;
                  if (off == `TFA_OFF_FAULT_ALIAS)
                     off = `TFA_OFF_FAULT;
               end
            end
            default: tgt = TFA_TGT_NONE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Sector buffer pointer; address bits never pick a location
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || sector_start_i)
      begin
         word_ptr_o <= '0;
         odd_ptr_o  <= 1'b0;
      end
      else if (rd_start || wr_start)
      begin
         case (tgt)
            TFA_TGT_WORD:
            begin
               word_ptr_o <= word_ptr_o + AW'(1);
               odd_ptr_o  <= 1'b0;
            end
            TFA_TGT_EVEN:
            begin
               odd_ptr_o <= ~odd_ptr_o;
               if (odd_ptr_o)
                  word_ptr_o <= word_ptr_o + AW'(1);
            end
            TFA_TGT_ODD:
            begin
               word_ptr_o <= word_ptr_o + AW'(1);
               odd_ptr_o  <= 1'b0;
            end
            default: odd_ptr_o <= odd_ptr_o;
         endcase
      end
   end

   assign cur_word = buf_mem[word_ptr_o];
   assign wr_byte  = hi_lane ? card.data_bus[15:8] : card.data_bus[7:0];

   // Host writes take the slot over a controller write in the same cycle
   always_ff @(posedge mclk_i)
   begin
      if (wr_start && tgt == TFA_TGT_WORD)
         buf_mem[word_ptr_o] <= card.data_bus;
      else if (wr_start && tgt == TFA_TGT_EVEN && !odd_ptr_o)
         buf_mem[word_ptr_o][7:0] <= wr_byte;
      else if (wr_start && (tgt == TFA_TGT_ODD || tgt == TFA_TGT_EVEN))
         buf_mem[word_ptr_o][15:8] <= wr_byte;
      else if (buf_we_i)
         buf_mem[buf_addr_i] <= buf_wdata_i;
   end

   assign buf_rdata_o = buf_mem[buf_addr_i];

   // ----------------------------------------------------------------------
   // Task file
   // ----------------------------------------------------------------------
   always_comb
   begin
      case (off)
         `TFA_OFF_FAULT:     reg_rd = error_i;
         `TFA_OFF_COUNT:     reg_rd = count_o;
         `TFA_OFF_BLOCK:     reg_rd = block_o;
         `TFA_OFF_TRK_LOW:   reg_rd = track_low_o;
         `TFA_OFF_TRK_HIGH:  reg_rd = track_high_o;
         `TFA_OFF_UNIT:      reg_rd = unit_o;
         `TFA_OFF_STATE:     reg_rd = status_i;
         `TFA_OFF_SHADOW:    reg_rd = status_i;
         `TFA_OFF_UNIT_ADDR: reg_rd = drive_addr_i;
         default:            reg_rd = `TFA_RST_BYTE;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         option_o     <= `TFA_RST_BYTE;
         count_o      <= `TFA_RST_BYTE;
         block_o      <= `TFA_RST_BYTE;
         track_low_o  <= `TFA_RST_BYTE;
         track_high_o <= `TFA_RST_BYTE;
         unit_o       <= `TFA_RST_BYTE;
         opcode_o     <= `TFA_RST_BYTE;
         control_o    <= `TFA_RST_BYTE;
      end
      else if (wr_start && tgt == TFA_TGT_REG)
      begin
         case (off)
            `TFA_OFF_FAULT:    option_o     <= wr_byte;
            `TFA_OFF_COUNT:    count_o      <= wr_byte;
            `TFA_OFF_BLOCK:    block_o      <= wr_byte;
            `TFA_OFF_TRK_LOW:  track_low_o  <= wr_byte;
            `TFA_OFF_TRK_HIGH: track_high_o <= wr_byte;
            `TFA_OFF_UNIT:     unit_o       <= wr_byte;
            `TFA_OFF_STATE:    opcode_o     <= wr_byte;
            `TFA_OFF_SHADOW:   control_o    <= wr_byte;
            default:           control_o    <= control_o;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         opcode_stb_o <= 1'b0;
      else
         opcode_stb_o <= wr_start && tgt == TFA_TGT_REG && off == `TFA_OFF_STATE;
   end

   // ----------------------------------------------------------------------
   // Read data; latched at the strobe edge, driven until the strobe ends
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         card.dev_data    <= `TFA_RST_WORD;
         card.dev_data_oe <= 1'b0;
      end
      else if (rd_start && tgt != TFA_TGT_NONE)
      begin
         card.dev_data_oe <= 1'b1;
         case (tgt)
            TFA_TGT_WORD: card.dev_data <= cur_word;
            TFA_TGT_EVEN:
               card.dev_data <= {8'h00, odd_ptr_o ? cur_word[15:8] : cur_word[7:0]};
            TFA_TGT_ODD:
               card.dev_data <= hi_lane ? {cur_word[15:8], 8'h00}
                                        : {8'h00, cur_word[15:8]};
            default:
               card.dev_data <= hi_lane ? {reg_rd, 8'h00} : {8'h00, reg_rd};
         endcase
      end
      else if (card.read_n)
         card.dev_data_oe <= 1'b0;
   end
endmodule

`default_nettype wire

// ### include/tfa_defines.svh
/*
 * Task-file decoder constants: register offsets, reset values and timing.
 * Assumes inclusion by its bare name from the device and host design files.
 */
`ifndef TFA_DEFINES_SVH
`define TFA_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TFA_OFF_DATA        4'h0
`define TFA_OFF_FAULT       4'h1
`define TFA_OFF_COUNT       4'h2
`define TFA_OFF_BLOCK       4'h3
`define TFA_OFF_TRK_LOW     4'h4
`define TFA_OFF_TRK_HIGH    4'h5
`define TFA_OFF_UNIT        4'h6
`define TFA_OFF_STATE       4'h7
`define TFA_OFF_EVEN_ALIAS  4'h8
`define TFA_OFF_ODD_ALIAS   4'h9
`define TFA_OFF_FAULT_ALIAS 4'hd
`define TFA_OFF_SHADOW      4'he
`define TFA_OFF_UNIT_ADDR   4'hf

// ----------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------
`define TFA_ADDR_W          11
`define TFA_WINDOW_BIT      10
`define TFA_IDE_SHADOW_ADDR 3'h6
`define TFA_ODD_FLAG_ADDR   3'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TFA_RST_BYTE        8'h00
`define TFA_RST_WORD        16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TFA_CLK_NS          25
`define TFA_STROBE_NS       75
`define TFA_STROBE_CYC      ((`TFA_STROBE_NS + `TFA_CLK_NS - 1) / `TFA_CLK_NS)

`endif

// ### include/tfa_pkg.sv
/*
 * Shared types of the task-file decoder: access targets and host states.
 * Assumes tfa_defines.svh is on the include path.
 */
package tfa_pkg;

   // Decoded meaning of one card access
   typedef enum logic [2:0]
   {
      TFA_TGT_NONE = 3'h0,
      TFA_TGT_WORD = 3'h1,
      TFA_TGT_EVEN = 3'h2,
      TFA_TGT_ODD  = 3'h3,
      TFA_TGT_REG  = 3'h4
   } tfa_target_t;

   // Host cycle sequencer
   typedef enum logic [3:0]
   {
      TFA_H_IDLE   = 4'b0001,
      TFA_H_SETUP  = 4'b0010,
      TFA_H_STROBE = 4'b0100,
      TFA_H_RECOV  = 4'b1000
   } tfa_host_state_t;

endpackage

// ### include/tfa_if.sv
/*
 * Card connector between the host end and the card end.
 * Assumes both ends run on the same clock; resolves the shared data bus.
 */
`timescale 1ns/100ps
`default_nettype none

interface tfa_if;
   logic        attr_select;
   logic [10:0] addr;
   logic        low_lane_enable_n;
   logic        high_lane_enable_n;
   logic        command_block_select_n;
   logic        control_block_select_n;
   logic        dma_ack_n;
   logic        read_n;
   logic        write_n;
   logic [15:0] host_data;
   logic        host_data_oe;
   logic [15:0] dev_data;
   logic        dev_data_oe;
   logic        wide_io_indicator_n;
   logic [15:0] data_bus;

   // ----------------------------------------------------------------------
   // Wire level of the shared data bus
   // ----------------------------------------------------------------------
   assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 16'h0000);

   modport host
   (
      output attr_select, addr, low_lane_enable_n, high_lane_enable_n,
      output command_block_select_n, control_block_select_n, dma_ack_n,
      output read_n, write_n, host_data, host_data_oe,
      input  dev_data_oe, wide_io_indicator_n, data_bus
   );

   modport device
   (
      input  attr_select, addr, low_lane_enable_n, high_lane_enable_n,
      input  command_block_select_n, control_block_select_n, dma_ack_n,
      input  read_n, write_n, data_bus,
      output dev_data, dev_data_oe, wide_io_indicator_n
   );
endinterface

`default_nettype wire

// ### verilog/tfa_host.sv
/*
 * Host end: runs one strobe-qualified register cycle per user request.
 * Assumes the card end shares mclk_i and answers within the strobe.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tfa_defines.svh"

module tfa_host
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // Card connector
   tfa_if.host              card,
   // User request
   input  wire logic        req_i,
   input  wire logic        req_wr_i,
   input  wire logic        mem_space_i,
   input  wire logic        ide_i,
   input  wire logic        dma_i,
   input  wire logic [10:0] addr_i,
   input  wire logic [1:0]  lanes_i,
   input  wire logic [15:0] wdata_i,
   // User answer
   output logic             busy_o,
   output logic             done_o,
   output logic [15:0]      rdata_o
);
   import tfa_pkg::*;

   localparam logic [3:0] STROBE_CYC = 4'(`TFA_STROBE_CYC);

   tfa_host_state_t state;
   tfa_host_state_t next_state;
   logic [3:0]      cnt;
   logic            wr_q;

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         TFA_H_IDLE:   if (req_i) next_state = TFA_H_SETUP;
         TFA_H_SETUP:  next_state = TFA_H_STROBE;
         TFA_H_STROBE: if (cnt == STROBE_CYC - 4'h1) next_state = TFA_H_RECOV;
         TFA_H_RECOV:  next_state = TFA_H_IDLE;
         default:      next_state = TFA_H_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         state <= TFA_H_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || state != TFA_H_STROBE)
         cnt <= 4'h0;
      else
         cnt <= cnt + 4'h1;
   end

   // ----------------------------------------------------------------------
   // Address phase; held from setup through recovery
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         card.attr_select            <= 1'b0;
         card.addr                   <= 11'h000;
         card.low_lane_enable_n      <= 1'b1;
         card.high_lane_enable_n     <= 1'b1;
         card.command_block_select_n <= 1'b1;
         card.control_block_select_n <= 1'b1;
         card.dma_ack_n              <= 1'b1;
         card.host_data              <= `TFA_RST_WORD;
         wr_q                        <= 1'b0;
      end
      else if (state == TFA_H_IDLE && req_i)
      begin
         card.attr_select            <= mem_space_i;
         card.addr                   <= addr_i;
         card.low_lane_enable_n      <= ~(lanes_i[0] & ~ide_i);
         card.high_lane_enable_n     <= ~(lanes_i[1] & ~ide_i);
         card.command_block_select_n <= ~(ide_i & ~dma_i & ~addr_i[3]);
         card.control_block_select_n <= ~(ide_i & ~dma_i & addr_i[3]);
         card.dma_ack_n              <= ~(ide_i & dma_i);
         card.host_data              <= wdata_i;
         wr_q                        <= req_wr_i;
      end
      else if (state == TFA_H_RECOV)
      begin
         card.low_lane_enable_n      <= 1'b1;
         card.high_lane_enable_n     <= 1'b1;
         card.command_block_select_n <= 1'b1;
         card.control_block_select_n <= 1'b1;
         card.dma_ack_n              <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Strobes and data
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         card.read_n       <= 1'b1;
         card.write_n      <= 1'b1;
         card.host_data_oe <= 1'b0;
      end
      else
      begin
         card.read_n       <= ~(next_state == TFA_H_STROBE && !wr_q);
         card.write_n      <= ~(next_state == TFA_H_STROBE && wr_q);
         card.host_data_oe <= (next_state == TFA_H_STROBE) && wr_q;
      end
   end

   // Sampled on the last strobe cycle, when the card data has settled
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         rdata_o <= `TFA_RST_WORD;
         done_o  <= 1'b0;
      end
      else
      begin
         done_o <= (state == TFA_H_RECOV);
         if (state == TFA_H_STROBE && cnt == STROBE_CYC - 4'h1 && !wr_q)
            rdata_o <= card.data_bus;
      end
   end

   assign busy_o = (state != TFA_H_IDLE);
endmodule

`default_nettype wire

// ### sim/tfa_monitor.sv
/* Checker on the card connector: strobe shapes, bus ownership, answers.
   Assumes one clock for both ends; instantiated beside the interface. */
`timescale 1ns/100ps
`default_nettype none
module tfa_monitor
(
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // Connector
   input  wire logic        attr_select,
   input  wire logic [10:0] addr,
   input  wire logic        low_lane_enable_n,
   input  wire logic        high_lane_enable_n,
   input  wire logic        command_block_select_n,
   input  wire logic        control_block_select_n,
   input  wire logic        dma_ack_n,
   input  wire logic        read_n,
   input  wire logic        write_n,
   input  wire logic        host_data_oe,
   input  wire logic        dev_data_oe,
   input  wire logic        wide_io_indicator_n
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // ------------
   // Strobe shapes
   // ------------
   sequence s_rd_low;
      !read_n[*3] ##1 read_n;
   endsequence
   sequence s_wr_low;
      (!write_n && host_data_oe)[*3] ##1 write_n;
   endsequence
   a_rd_strobe_len:
      assert property ($fell(read_n) |-> s_rd_low) else $error("read strobe length wrong");
   a_wr_strobe_len:
      assert property ($fell(write_n) |-> s_wr_low) else $error("write strobe length wrong");
   a_oe_release:
      assert property ($rose(read_n) |=> !dev_data_oe) else $error("card drives after read");
   a_no_contention:
      assert property (!(dev_data_oe && host_data_oe)) else $error("both ends drive bus");
   a_word_answer:
      assert property ($fell(read_n) && attr_select && !addr[10] && addr[3:0] == 4'h0
         && !low_lane_enable_n && !high_lane_enable_n |=> dev_data_oe)
         else $error("no answer to word read");
   a_window_answer:
      assert property ($fell(read_n) && attr_select && addr[10] && !low_lane_enable_n
         |=> dev_data_oe) else $error("no answer in data window");
   a_dma_answer:
      assert property ($fell(read_n) && !dma_ack_n |=> dev_data_oe)
         else $error("no answer to dma read");
   a_disk_answer:
      assert property ($fell(read_n) && !command_block_select_n && control_block_select_n
         && dma_ack_n |=> dev_data_oe) else $error("no answer to disk register read");
   a_wide_io_mem:
      assert property (attr_select |-> wide_io_indicator_n)
         else $error("wide indicator in memory cycle");
endmodule
`default_nettype wire

// ### sim/testbench.sv
/* Bench: host end and card end joined by the connector, both user sides driven.
   Assumes package, interface, design and checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import tfa_pkg::*;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        req = 1'b0, wr = 1'b0, mem = 1'b1, ide = 1'b0, dma = 1'b0;
   logic        sec = 1'b0, we = 1'b0, bm = 1'b0, done, odd;
   logic [10:0] addr = 11'h000;
   logic [1:0]  ln = 2'h0;
   logic [15:0] wd = 16'h0000, rd, brd;
   logic [3:0]  ba = 4'h0, wp;
   logic [7:0]  opt, cnt, blk, opc, ctl;
   int          fails = 0, n_compared = 0;
   // Buffer word k holds even byte k and odd byte 1k: {addr, lanes, expected}
   logic [31:0] rtab [15] = '{32'h00031000, 32'h00131101, 32'h00831202, 32'h00931303,
      32'h00010004, 32'h00010014, 32'h00810005, 32'h00910015, 32'h7fe10006, 32'h40110016,
      32'h00821700, 32'h00028400, 32'h00d38400, 32'h00910018, 32'h00810009};
   tfa_if card ();
   tfa_host u_tfa_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .card(card), .req_i(req),
      .req_wr_i(wr), .mem_space_i(mem), .ide_i(ide), .dma_i(dma), .addr_i(addr),
      .lanes_i(ln), .wdata_i(wd), .busy_o(), .done_o(done), .rdata_o(rd));
   tfa_device #(.BUF_WORDS(16)) u_tfa_device (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .card(card), .ide_mode_i(ide), .byte_mode_i(bm), .long_byte_i(1'b0),
      .sector_start_i(sec), .status_i(8'h51), .error_i(8'h84), .drive_addr_i(8'h3e),
      .buf_addr_i(ba), .buf_we_i(we), .buf_wdata_i(wd), .buf_rdata_o(brd), .word_ptr_o(wp),
      .odd_ptr_o(odd), .option_o(opt), .count_o(cnt), .block_o(blk), .track_low_o(),
      .track_high_o(), .unit_o(), .opcode_o(opc), .opcode_stb_o(), .control_o(ctl));
   tfa_monitor u_tfa_monitor (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .attr_select(card.attr_select), .addr(card.addr),
      .low_lane_enable_n(card.low_lane_enable_n), .high_lane_enable_n(card.high_lane_enable_n),
      .command_block_select_n(card.command_block_select_n),
      .control_block_select_n(card.control_block_select_n), .dma_ack_n(card.dma_ack_n),
      .read_n(card.read_n), .write_n(card.write_n), .host_data_oe(card.host_data_oe),
      .dev_data_oe(card.dev_data_oe), .wide_io_indicator_n(card.wide_io_indicator_n));
   always #12.5 mclk_i = ~mclk_i;
   // ------------
   // Tasks
   // ------------
   task automatic chk(input logic [15:0] got, exp, input string nm);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim;
      if (fails == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Entered at a rising edge; done is sampled before that edge's updates land
   task automatic acc(input logic w, m, i, d, input logic [10:0] a, input logic [1:0] l,
                      input logic [15:0] v);
      int n = 0;
      req <= 1'b1;
      wr <= w;
      mem <= m;
      ide <= i;
      dma <= d;
      addr <= a;
      ln <= l;
      wd <= v;
      @(posedge mclk_i);
      req <= 1'b0;
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while (done !== 1'b1 && n < 20);
      if (n >= 20)
         fails++;
   endtask
   task automatic restart;
      sec <= 1'b1;
      @(posedge mclk_i);
      sec <= 1'b0;
      @(posedge mclk_i);
   endtask
   initial
   begin
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      for (int k = 0; k < 16; k++)
      begin
         ba <= k[3:0];
         wd <= {4'h1, k[3:0], 4'h0, k[3:0]};
         we <= 1'b1;
         @(posedge mclk_i);
      end
      we <= 1'b0;
      restart();
      foreach (rtab[j])
      begin
         acc(1'b0, 1'b1, 1'b0, 1'b0, rtab[j][30:20], rtab[j][17:16], 16'h0000);
         chk(rd & {{8{rtab[j][17]}}, {8{rtab[j][16]}}}, rtab[j][15:0], "card read");
      end
      chk({11'h000, odd, wp}, 16'h0019, "fifo pointer");
      ba <= 4'h9;
      acc(1'b1, 1'b1, 1'b0, 1'b0, 11'h008, 2'h3, 16'hbeef);
      chk(brd, 16'hbeef, "buffer word write");
      ba <= 4'ha;
      acc(1'b1, 1'b1, 1'b0, 1'b0, 11'h000, 2'h1, 16'h00c3);
      acc(1'b1, 1'b1, 1'b0, 1'b0, 11'h000, 2'h1, 16'h005a);
      chk(brd, 16'h5ac3, "buffer byte pair");
      acc(1'b1, 1'b1, 1'b0, 1'b0, 11'h3f2, 2'h1, 16'h00a5);
      chk({8'h00, cnt}, 16'h00a5, "count");
      acc(1'b1, 1'b1, 1'b0, 1'b0, 11'h002, 2'h2, 16'h5a00);
      chk({8'h00, blk}, 16'h005a, "upper lane block");
      acc(1'b1, 1'b1, 1'b0, 1'b0, 11'h000, 2'h2, 16'h3c00);
      chk({8'h00, opt}, 16'h003c, "option");
      acc(1'b1, 1'b1, 1'b0, 1'b0, 11'h007, 2'h1, 16'h00ec);
      chk({8'h00, opc}, 16'h00ec, "opcode");
      acc(1'b0, 1'b0, 1'b0, 1'b0, 11'h00f, 2'h1, 16'h0000);
      chk(rd & 16'h00ff, 16'h003e, "io drive address");
      restart();
      acc(1'b0, 1'b1, 1'b1, 1'b0, 11'h007, 2'h0, 16'h0000);
      chk(rd & 16'h00ff, 16'h0051, "disk status");
      acc(1'b0, 1'b1, 1'b1, 1'b0, 11'h00e, 2'h0, 16'h0000);
      chk(rd & 16'h00ff, 16'h0051, "disk alt status");
      acc(1'b1, 1'b1, 1'b1, 1'b0, 11'h00e, 2'h0, 16'h0006);
      chk({8'h00, ctl}, 16'h0006, "disk control");
      acc(1'b0, 1'b1, 1'b1, 1'b0, 11'h000, 2'h0, 16'h0000);
      chk(rd, 16'h1000, "disk pio word");
      acc(1'b0, 1'b1, 1'b1, 1'b1, 11'h3ff, 2'h0, 16'h0000);
      chk(rd, 16'h1101, "disk dma word");
      bm <= 1'b1;
      acc(1'b0, 1'b1, 1'b1, 1'b0, 11'h000, 2'h0, 16'h0000);
      chk(rd, 16'h0002, "disk byte even");
      acc(1'b0, 1'b1, 1'b1, 1'b0, 11'h000, 2'h0, 16'h0000);
      chk(rd, 16'h0012, "disk byte odd");
      acc(1'b0, 1'b0, 1'b0, 1'b0, 11'h000, 2'h2, 16'h0000);
      chk(rd, 16'h0000, "refused upper lane");
      end_sim();
   end
   initial
   begin
      #50000;
      fails++;
      end_sim();
   end
endmodule
`default_nettype wire
